/* File: shared/spi_port_pkg.sv */
// Constants, types and carriers for the dual serial peripheral port
//
// Functional notes
// - Serial clock divides main clock by 4,16,64,128,2,8,32,64 per select.
// - A data register write in master mode while idle launches a transfer once the receive buffer has room, even to receive.
// - Completion sets the done flag and requests an interrupt if enabled.
// - With interrupt enabled, entering service clears the done flag.
// - With interrupt off, status read then data access clears done flag.
// - Data register write during a transfer sets the collision flag.
// - Status read then data register access clears the collision flag.
// - Select pin rising edge sets the select-high flag when pin is input and the port is enabled.
// - Writing zero clears the select-high flag; writing one does nothing.
// - Select pin enable turns the select pin function on or off.
// - Transmit enable permits or suppresses outgoing data.
// - Receive enable permits or suppresses capture of incoming data.
// - Two independent ports, each with own data and status registers.
// - Polarity bit sets the idle level of the serial clock.
// - Phase bit picks sampling on leading or trailing clock edge.
package spi_port_pkg;

    localparam int PORT_COUNT = 2;
    localparam int ADDR_WIDTH = 10;
    localparam int DATA_WIDTH = 8;
    localparam int CTRL_WIDTH = 9;
    localparam int HALF_WIDTH = 6;
    localparam int BUF_DEPTH = 2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA [PORT_COUNT] = '{8'hd3, 8'h93};
    localparam logic [7:0] IDX_FLAGS [PORT_COUNT] = '{8'hd4, 8'hf1};
    localparam logic [7:0] IDX_CTRL [PORT_COUNT] = '{8'hd2, 8'hf2};
    localparam logic [1:0] LANE_ALIGNED = 2'h0;

    // Flag register fields
    localparam int FLAG_DONE = 7;
    localparam int FLAG_COLL = 6;
    localparam int FLAG_SSHI = 5;
    localparam int FLAG_SSEN = 2;
    localparam int FLAG_TXEN = 1;
    localparam int FLAG_RXEN = 0;

    // Control register fields
    localparam int CTRL_IRQEN = 8;
    localparam int CTRL_ENABLE = 7;
    localparam int CTRL_LSB = 6;
    localparam int CTRL_MASTER = 5;
    localparam int CTRL_IDLE_LEVEL_SELECT = 4;
    localparam int CTRL_SAMPLE_EDGE_SELECT = 3;
    localparam int CTRL_RATE_HI = 2;

    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [HALF_WIDTH-1:0] HALF_STEP = 6'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACTIVE = 2'b11,
        ST_END = 2'b10
    } phase_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ss;
    } spi_pins_t;

    // Half period minus one, in main clock cycles
    function automatic logic [HALF_WIDTH-1:0] rate_half(
        input logic [2:0] sel
    );
        case (sel)
            3'h0: rate_half = 6'h01;
            3'h1: rate_half = 6'h07;
            3'h2: rate_half = 6'h1f;
            3'h3: rate_half = 6'h3f;
            3'h4: rate_half = 6'h00;
            3'h5: rate_half = 6'h03;
            3'h6: rate_half = 6'h0f;
            default: rate_half = 6'h1f;
        endcase
    endfunction : rate_half

    typedef struct packed {
        phase_t phase;
        logic [HALF_WIDTH-1:0] half_cnt;
        logic [3:0] bit_cnt;
        logic [DATA_WIDTH-1:0] shift;
        logic [DATA_WIDTH-1:0] data_hold;
        logic sample;
        logic out_bit;
        logic master_sclk;
        logic armed;
        logic status_seen;
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [DATA_WIDTH-1:0] flags;
        spi_pins_t sync1;
        spi_pins_t sync2;
        logic sclk_prev;
        logic ss_prev;
    } port_state_t;

    typedef struct packed {
        port_state_t [PORT_COUNT-1:0] port;
        logic [CTRL_WIDTH-1:0] rdata;
        logic slverr;
    } top_state_t;

endpackage : spi_port_pkg

/* File: verilog/spi_rx_buffer.sv */
// Small valid/ready buffer for received bytes
`timescale 1ns/1ps
module spi_rx_buffer
    import spi_port_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [WIDTH-1:0] push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WIDTH-1:0] pop_data
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] entry;
        logic [CW-1:0] count;
    } buf_state_t;

    buf_state_t st;
    buf_state_t next_st;
    logic do_push;
    logic do_pop;

    assign push_ready = (st.count != FULL_COUNT);
    assign pop_valid = (st.count != '0);
    assign pop_data = st.entry[0];

    always_comb begin
        next_st = st;
        do_push = push_valid && push_ready;
        do_pop = pop_valid && pop_ready;
        // Pop moves entries down one place
        if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_st.entry[i] = st.entry[i+1];
            end
            next_st.count = st.count - ONE;
        end
        if (do_push) begin
            next_st.entry[next_st.count] = push_data;
            next_st.count = next_st.count + ONE;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : spi_rx_buffer

/* File: verilog/spi_dual_port.sv */
// Two serial peripheral ports with an APB register slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module spi_dual_port
    import spi_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spi_pins_t [PORT_COUNT-1:0] pin_in,
    output spi_pins_t [PORT_COUNT-1:0] pin_out,
    output spi_pins_t [PORT_COUNT-1:0] pin_oe,
    input wire logic [PORT_COUNT-1:0] irq_service,
    output logic [PORT_COUNT-1:0] xfer_irq
);
    top_state_t st;
    top_state_t next_st;

    logic [PORT_COUNT-1:0] push_valid;
    logic [PORT_COUNT-1:0] push_ready;
    logic [DATA_WIDTH-1:0] push_data [PORT_COUNT];
    logic [PORT_COUNT-1:0] pop_valid;
    logic [PORT_COUNT-1:0] pop_ready;
    logic [DATA_WIDTH-1:0] pop_data [PORT_COUNT];

    // Received bytes wait here until software reads them
    for (genvar g = 0; g < PORT_COUNT; g++) begin : g_buf
        spi_rx_buffer #(
            .WIDTH(DATA_WIDTH),
            .DEPTH(BUF_DEPTH)
        ) u_rx_buffer (
            .mclk(mclk),
            .reset_n(reset_n),
            .push_valid(push_valid[g]),
            .push_ready(push_ready[g]),
            .push_data(push_data[g]),
            .pop_valid(pop_valid[g]),
            .pop_ready(pop_ready[g]),
            .pop_data(pop_data[g])
        );
    end

    // First bit to drive for a given byte
    function automatic logic first_bit(
        input logic [DATA_WIDTH-1:0] d,
        input logic lsb
    );
        first_bit = lsb ? d[0] : d[DATA_WIDTH-1];
    endfunction : first_bit

    assign pready = 1'b1;
    assign pslverr = st.slverr;
    assign prdata = {{(32 - CTRL_WIDTH){1'b0}}, st.rdata};

    always_comb begin
        port_state_t ps;
        port_state_t cur;
        logic [7:0] idx;
        logic aligned;
        logic setup;
        logic access;
        logic hit;
        logic en;
        logic master;
        logic idle_level_select;
        logic sample_edge_select;
        logic lsb;
        logic irqen;
        logic ssen;
        logic selected;
        logic ss_input;
        logic sdi;
        logic sbit;
        logic lead_ev;
        logic trail_ev;
        logic done_ev;
        logic coll_ev;
        logic sshi_ev;
        logic busy;
        logic [DATA_WIDTH-1:0] new_shift;
        logic [HALF_WIDTH-1:0] half;
        logic data_acc;
        ps = '0;
        cur = '0;
        idx = paddr[ADDR_WIDTH-1:2];
        aligned = (paddr[1:0] == LANE_ALIGNED);
        setup = psel && !penable;
        access = psel && penable;
        hit = 1'b0;
        en = 1'b0;
        master = 1'b0;
        idle_level_select = 1'b0;
        sample_edge_select = 1'b0;
        lsb = 1'b0;
        irqen = 1'b0;
        ssen = 1'b0;
        selected = 1'b0;
        ss_input = 1'b0;
        sdi = 1'b0;
        sbit = 1'b0;
        lead_ev = 1'b0;
        trail_ev = 1'b0;
        done_ev = 1'b0;
        coll_ev = 1'b0;
        sshi_ev = 1'b0;
        busy = 1'b0;
        new_shift = '0;
        half = '0;
        data_acc = 1'b0;
        next_st = st;
        push_valid = '0;
        pop_ready = '0;
        pin_out = '0;
        pin_oe = '0;
        xfer_irq = '0;

        for (int p = 0; p < PORT_COUNT; p++) begin
            cur = st.port[p];
            ps = cur;
            push_data[p] = '0;
            sbit = 1'b0;
            new_shift = '0;
            en = cur.ctrl[CTRL_ENABLE];
            master = cur.ctrl[CTRL_MASTER];
            idle_level_select = cur.ctrl[CTRL_IDLE_LEVEL_SELECT];
            sample_edge_select = cur.ctrl[CTRL_SAMPLE_EDGE_SELECT];
            lsb = cur.ctrl[CTRL_LSB];
            irqen = cur.ctrl[CTRL_IRQEN];
            ssen = cur.flags[FLAG_SSEN];
            half = rate_half(cur.ctrl[CTRL_RATE_HI:0]);
            lead_ev = 1'b0;
            trail_ev = 1'b0;
            done_ev = 1'b0;
            coll_ev = 1'b0;

            // Pin synchronisers
            ps.sync1 = pin_in[p];
            ps.sync2 = cur.sync1;
            ps.sclk_prev = cur.sync2.sclk;
            ps.ss_prev = cur.sync2.ss;

            ss_input = !(master && ssen);
            selected = !ssen || !cur.sync2.ss;
            // Select-high edge, only while the port is on
            sshi_ev = en && ss_input && cur.sync2.ss
                      && !cur.ss_prev;
            // Data input depends on role
            sdi = master ? cur.sync2.miso : cur.sync2.mosi;
            // Slave counts as busy once a bit has shifted
            busy = master ? (cur.phase != ST_IDLE)
                          : (cur.bit_cnt != '0);

            // Master clock generator
            case (cur.phase)
                ST_IDLE: begin
                    ps.master_sclk = idle_level_select;
                    if (en && master && cur.armed && push_ready[p]) begin
                        ps.phase = ST_SETUP;
                        ps.half_cnt = half;
                        ps.bit_cnt = '0;
                        ps.armed = 1'b0;
                    end
                end
                ST_SETUP: begin
                    if (cur.half_cnt == '0) begin
                        lead_ev = 1'b1;
                        ps.master_sclk = !idle_level_select;
                        ps.phase = ST_ACTIVE;
                        ps.half_cnt = half;
                    end else begin
                        ps.half_cnt = cur.half_cnt - HALF_STEP;
                    end
                end
                ST_ACTIVE: begin
                    if (cur.half_cnt == '0) begin
                        trail_ev = 1'b1;
                        ps.master_sclk = idle_level_select;
                        ps.half_cnt = half;
                        ps.phase = (cur.bit_cnt == LAST_BIT) ? ST_END
                                                             : ST_SETUP;
                    end else begin
                        ps.half_cnt = cur.half_cnt - HALF_STEP;
                    end
                end
                ST_END: begin
                    if (cur.half_cnt == '0) begin
                        ps.phase = ST_IDLE;
                    end else begin
                        ps.half_cnt = cur.half_cnt - HALF_STEP;
                    end
                end
                default: begin
                    ps.phase = ST_IDLE;
                end
            endcase

            // Slave edges come from the synchronised clock pin
            if (en && !master) begin
                if (!selected) begin
                    ps.bit_cnt = '0;
                end else if (cur.sync2.sclk != cur.sclk_prev) begin
                    lead_ev = (cur.sync2.sclk != idle_level_select);
                    trail_ev = (cur.sync2.sclk == idle_level_select);
                end
            end

            // Shift engine shared by both roles
            if (lead_ev) begin
                if (!sample_edge_select) begin
                    ps.sample = sdi;
                end else begin
                    ps.out_bit = first_bit(cur.shift, lsb);
                end
            end
            if (trail_ev) begin
                sbit = sample_edge_select ? sdi : cur.sample;
                new_shift = lsb ? {sbit, cur.shift[DATA_WIDTH-1:1]}
                                : {cur.shift[DATA_WIDTH-2:0], sbit};
                ps.shift = new_shift;
                ps.bit_cnt = cur.bit_cnt + BIT_STEP;
                if (!sample_edge_select) begin
                    ps.out_bit = first_bit(new_shift, lsb);
                end
                if (cur.bit_cnt == LAST_BIT) begin
                    done_ev = 1'b1;
                    ps.bit_cnt = '0;
                end
            end
            push_valid[p] = done_ev && cur.flags[FLAG_RXEN];
            push_data[p] = new_shift;

            // Register accesses for this port
            data_acc = access && aligned && (idx == IDX_DATA[p]);
            if (data_acc && !pwrite) begin
                pop_ready[p] = 1'b1;
            end
            if (pop_valid[p] && pop_ready[p]) begin
                ps.data_hold = pop_data[p];
            end
            if (data_acc && pwrite) begin
                if (busy) begin
                    coll_ev = 1'b1;
                end else begin
                    ps.shift = pwdata[DATA_WIDTH-1:0];
                    ps.out_bit = first_bit(pwdata[DATA_WIDTH-1:0], lsb);
                    ps.armed = 1'b1;
                end
            end
            // Status read then data access clears flags
            if (data_acc && cur.status_seen) begin
                ps.status_seen = 1'b0;
                ps.flags[FLAG_COLL] = 1'b0;
                if (!irqen) begin
                    ps.flags[FLAG_DONE] = 1'b0;
                end
            end
            // Service entry clears the done flag
            if (irqen && irq_service[p]) begin
                ps.flags[FLAG_DONE] = 1'b0;
            end
            // Status register access
            if (access && aligned && (idx == IDX_FLAGS[p])) begin
                if (pwrite) begin
                    ps.flags[FLAG_SSEN] = pwdata[FLAG_SSEN];
                    ps.flags[FLAG_TXEN] = pwdata[FLAG_TXEN];
                    ps.flags[FLAG_RXEN] = pwdata[FLAG_RXEN];
                    if (!pwdata[FLAG_SSHI]) begin
                        ps.flags[FLAG_SSHI] = 1'b0;
                    end
                end else begin
                    ps.status_seen = 1'b1;
                end
            end
            // Control register write
            if (access && aligned && pwrite && (idx == IDX_CTRL[p])) begin
                ps.ctrl = pwdata[CTRL_WIDTH-1:0];
            end

            // Hardware set wins over any clear in the same cycle
            if (done_ev) begin
                ps.flags[FLAG_DONE] = 1'b1;
            end
            if (coll_ev) begin
                ps.flags[FLAG_COLL] = 1'b1;
            end
            if (sshi_ev) begin
                ps.flags[FLAG_SSHI] = 1'b1;
            end
            next_st.port[p] = ps;

            // Pin drive
            pin_out[p].sclk = cur.master_sclk;
            pin_oe[p].sclk = en && master;
            pin_out[p].mosi = cur.out_bit;
            pin_oe[p].mosi = en && master && cur.flags[FLAG_TXEN];
            pin_out[p].miso = cur.out_bit;
            pin_oe[p].miso = en && !master && selected
                             && cur.flags[FLAG_TXEN];
            pin_out[p].ss = (cur.phase == ST_IDLE);
            pin_oe[p].ss = en && master && ssen;
            xfer_irq[p] = irqen && cur.flags[FLAG_DONE];
        end

        // Read data and error are captured in the setup cycle
        if (setup) begin
            next_st.rdata = '0;
            hit = 1'b0;
            for (int p = 0; p < PORT_COUNT; p++) begin
                if (aligned && idx == IDX_DATA[p]) begin
                    hit = 1'b1;
                    next_st.rdata = {1'b0, pop_valid[p] ? pop_data[p]
                                           : st.port[p].data_hold};
                end
                if (aligned && idx == IDX_FLAGS[p]) begin
                    hit = 1'b1;
                    next_st.rdata = {1'b0, st.port[p].flags};
                end
                if (aligned && idx == IDX_CTRL[p]) begin
                    hit = 1'b1;
                    next_st.rdata = st.port[p].ctrl;
                end
            end
            next_st.slverr = !hit;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : spi_dual_port

/* File: dv/spi_port_chk.sv */
// Port-level assertions for the dual serial port
`timescale 1ns/1ps
module spi_port_chk
    import spi_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire spi_pins_t [PORT_COUNT-1:0] pin_in,
    input wire spi_pins_t [PORT_COUNT-1:0] pin_out,
    input wire spi_pins_t [PORT_COUNT-1:0] pin_oe,
    input wire logic [PORT_COUNT-1:0] irq_service,
    input wire logic [PORT_COUNT-1:0] xfer_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire setup = psel && !penable;
    function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
        logic [7:0] x;
        x = a[9:2];
        mapped = (a[1:0] == LANE_ALIGNED)
            && (x inside {IDX_DATA, IDX_FLAGS, IDX_CTRL});
    endfunction : mapped
    sequence s_frame_open;
        $fell(pin_out[0].ss);
    endsequence
    sequence s_held_low;
        !pin_out[0].ss [*8];
    endsequence
    a_err_unmapped: assert property (
        setup && !mapped(paddr) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access without error");
    a_err_mapped: assert property (
        setup && mapped(paddr) |=> !pslverr)
        else $error("mapped access flagged as error");
    a_prdata_stands: assert property (!setup |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_frame_min: assert property (s_frame_open |-> s_held_low)
        else $error("select released too early");
    a_irq_release: assert property (
        $rose(xfer_irq[0]) |-> ##[0:70] pin_out[0].ss)
        else $error("request without frame end");
    a_service_clear: assert property (
        xfer_irq[0] && irq_service[0] |=> !xfer_irq[0])
        else $error("service did not clear request");
    a_sclk_idle: assert property (
        pin_out[0].ss && $past(pin_out[0].ss) && !$past(psel)
        && !$past(psel, 2) |-> $stable(pin_out[0].sclk))
        else $error("serial clock moved while idle");
    a_ss_oe: assert property (pin_oe[0].ss |-> pin_oe[0].sclk)
        else $error("select driven outside master role");
endmodule : spi_port_chk

/* File: dv/spi_slave_model.sv */
// Behavioural serial slave answering a counted byte
`timescale 1ns/1ps
module spi_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic [7:0] n = 8'h00;
    initial miso = 1'b0;
    initial got = 8'h00;
    // First bit set up before the leading edge
    always @(negedge ss) begin
        tx = 8'h3c + n;
        n = n + 8'h01;
        miso = tx[7];
    end
    always @(posedge sclk) begin
        if (!ss) rx = {rx[6:0], mosi};
    end
    always @(negedge sclk) begin
        if (!ss) begin
            tx = {tx[6:0], 1'b0};
            miso = tx[7];
        end
    end
    // Released line shows the inverse of its last level
    always @(posedge ss) begin
        got = rx;
        miso = ~miso;
    end
endmodule : spi_slave_model

/* File: dv/tb.sv */
// Self-checking bench for the dual serial port
`timescale 1ns/1ps
module tb;
    import spi_port_pkg::*;
    typedef struct packed {
        logic [2:0] rate;
        logic [7:0] tx;
        logic [7:0] div;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{3'h0, 8'ha5, 8'h04}, '{3'h1, 8'h5a, 8'h10},
        '{3'h2, 8'h81, 8'h40}, '{3'h3, 8'h7e, 8'h80},
        '{3'h4, 8'h01, 8'h02}, '{3'h5, 8'hc3, 8'h08},
        '{3'h6, 8'h3f, 8'h20}, '{3'h7, 8'hf0, 8'h40}};
    localparam logic [9:0] DA = {IDX_DATA[0], LANE_ALIGNED};
    localparam logic [9:0] FA = {IDX_FLAGS[0], LANE_ALIGNED};
    localparam logic [9:0] CA = {IDX_CTRL[0], LANE_ALIGNED};
    localparam logic [9:0] DB = {IDX_DATA[1], LANE_ALIGNED};
    localparam logic [9:0] FB = {IDX_FLAGS[1], LANE_ALIGNED};
    localparam logic [9:0] CB = {IDX_CTRL[1], LANE_ALIGNED};
    logic mclk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_WIDTH-1:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, miso_m, sck0, mosi0, ss0;
    spi_pins_t [PORT_COUNT-1:0] pin_in, pin_out, pin_oe;
    spi_pins_t p1 = 4'h1;
    logic [1:0] irq_service = 2'h0, xfer_irq;
    logic [7:0] got, fr = 8'h3c;
    int num_errors = 0, compares = 0, n;
    always #2.5 mclk = ~mclk;
    // Wire levels, pulled when released
    assign sck0 = pin_oe[0].sclk ? pin_out[0].sclk : 1'b0;
    assign mosi0 = pin_oe[0].mosi ? pin_out[0].mosi : 1'b1;
    assign ss0 = pin_oe[0].ss ? pin_out[0].ss : 1'b1;
    assign pin_in[0] = '{sclk: sck0, mosi: mosi0, miso: miso_m, ss: ss0};
    assign pin_in[1] = p1;
    spi_dual_port dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq_service(irq_service), .xfer_irq(xfer_irq));
    spi_slave_model peer (.sclk(sck0), .mosi(mosi0), .ss(ss0),
        .miso(miso_m), .got(got));
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] a, input logic [8:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {23'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [9:0] a, input logic [8:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [9:0] a, input logic [31:0] x, input logic ee);
        apb(1'b0, a, 9'h000);
        chk(r, x);
        chk({31'h0, e}, {31'h0, ee});
    endtask : rd
    task wait_lvl(input logic s, input logic v);
        do begin
            @(posedge mclk);
            n++;
        end while ((s ? ss0 : sck0) !== v);
    endtask : wait_lvl
    task frame;
        wait_lvl(1'b1, 1'b0);
        wait_lvl(1'b1, 1'b1);
    endtask : frame
    task end_sim;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        wr(FA, 9'h007);
        for (int k = 0; k < 8; k++) begin
            wr(CA, 9'h0a0 + ROWS[k].rate);
            wr(DA, {1'b0, ROWS[k].tx});
            wait_lvl(1'b0, 1'b1);
            n = 0;
            wait_lvl(1'b0, 1'b0);
            wait_lvl(1'b0, 1'b1);
            chk(n, ROWS[k].div);
            wait_lvl(1'b1, 1'b1);
            rd(FA, 32'h87, 1'b0);
            apb(1'b0, DA, 9'h000);
            if (ROWS[k].div >= 8'h08) chk(r, {24'h0, fr});
            chk({24'h0, got}, {24'h0, ROWS[k].tx});
            rd(FA, 32'h07, 1'b0);
            fr = fr + 8'h01;
        end
        // Collision, then fill the receive buffer until it stalls
        wr(CA, 9'h0a1);
        wr(DA, 9'h011);
        wr(DA, 9'h022);
        frame;
        rd(FA, 32'hc7, 1'b0);
        wr(DA, 9'h033);
        rd(FA, 32'h07, 1'b0);
        frame;
        rd(FA, 32'h87, 1'b0);
        wr(DA, 9'h044);
        repeat (40) @(posedge mclk);
        chk({31'h0, ss0}, 32'h1);
        rd(DA, {24'h0, fr}, 1'b0);
        frame;
        rd(DA, {24'h0, fr + 8'h01}, 1'b0);
        rd(DA, {24'h0, fr + 8'h02}, 1'b0);
        rd(FA, 32'h87, 1'b0);
        rd(DA, {24'h0, fr + 8'h02}, 1'b0);
        chk({24'h0, got}, 32'h44);
        fr = fr + 8'h03;
        // Interrupt raised and serviced
        wr(CA, 9'h1a1);
        wr(DA, 9'h055);
        frame;
        chk({30'h0, xfer_irq}, 32'h1);
        irq_service <= 2'h1;
        @(posedge mclk);
        irq_service <= 2'h0;
        @(posedge mclk);
        chk({30'h0, xfer_irq}, 32'h0);
        rd(FA, 32'h07, 1'b0);
        rd(DA, {24'h0, fr}, 1'b0);
        wr(CA, 9'h0b0);
        repeat (2) @(posedge mclk);
        chk({31'h0, sck0}, 32'h1);
        wr(CA, 9'h0f8);
        wr(DA, 9'h00f);
        frame;
        chk({24'h0, got}, 32'hf0);
        wr(CA, 9'h0a0);
        wr(FA, 9'h003);
        repeat (2) @(posedge mclk);
        chk({31'h0, pin_oe[0].ss}, 32'h0);
        wr(FA, 9'h007);
        repeat (2) @(posedge mclk);
        chk({31'h0, pin_oe[0].ss}, 32'h1);
        // Second port as slave
        wr(CB, 9'h080);
        wr(FB, 9'h002);
        repeat (2) @(posedge mclk);
        chk({31'h0, pin_oe[1].miso}, 32'h1);
        wr(FB, 9'h000);
        repeat (2) @(posedge mclk);
        chk({31'h0, pin_oe[1].miso}, 32'h0);
        p1.ss <= 1'b0;
        repeat (5) @(posedge mclk);
        p1.ss <= 1'b1;
        repeat (6) @(posedge mclk);
        rd(FB, 32'h20, 1'b0);
        wr(FB, 9'h020);
        rd(FB, 32'h20, 1'b0);
        wr(FB, 9'h000);
        rd(FB, 32'h00, 1'b0);
        // Reset in mid-run, then reset values and the map
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(DA, 32'h0, 1'b0);
        rd(FA, 32'h0, 1'b0);
        rd(CA, 32'h0, 1'b0);
        rd(DB, 32'h0, 1'b0);
        rd(FB, 32'h0, 1'b0);
        rd(10'h000, 32'h0, 1'b1);
        rd(DA + 10'h001, 32'h0, 1'b1);
        wr(FA, 9'h007);
        rd(FB, 32'h0, 1'b0);
        end_sim;
    end
endmodule : tb
bind spi_dual_port spi_port_chk chk_i (.mclk(mclk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_service(irq_service), .xfer_irq(xfer_irq));
